/* shared/plrt_pkg.sv */
// shared constants, timing counts and state encoding for the long-press reset timer
// assumes a single 100 MHz system clock; all long times are counted in 1 us ticks
package plrt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and time base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W     = 7;
  localparam int TICK_US        = TICK_PERIOD_NS / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // documented times, in their own units (hold is 7.5 s)
  localparam int HOLD_TIME_MS    = 7500;
  localparam int PULSE_TIME_MS   = 400;
  localparam int DETECT_TIME_US  = 150;
  localparam int STARTUP_TIME_US = 150;

  // the same times as counts of 1 us ticks
  localparam int HOLD_TICKS    = HOLD_TIME_MS * 1000 / TICK_US;
  localparam int PULSE_TICKS   = PULSE_TIME_MS * 1000 / TICK_US;
  localparam int DETECT_TICKS  = DETECT_TIME_US / TICK_US;
  localparam int STARTUP_TICKS = STARTUP_TIME_US / TICK_US;
  localparam int TIMER_W       = 24;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser and reset values
  localparam int   SYNC_STAGES   = 2;
  localparam logic OE_RESET      = 1'b0;
  localparam logic PULL_EN_RESET = 1'b1;
  localparam logic STRAP_RESET   = 1'b0;
  localparam logic SYNC_RESET    = 1'b1;

  typedef enum logic [2:0] {
    ST_STARTUP  = 3'h0,
    ST_IDLE     = 3'h1,
    ST_HOLD     = 3'h2,
    ST_PULSE    = 3'h3,
    ST_WAIT_REL = 3'h4
  } plrt_state_t;

endpackage : plrt_pkg

/* shared/plrt_tick_if.sv */
// carrier for the 1 us time-base enable between the divider and the timer
// assumes both ends sit on clk_sys
`timescale 1ns/1ns
interface plrt_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input  tick);
endinterface : plrt_tick_if

/* logic/plrt_tick_gen.sv */
// divider making a one-cycle enable every microsecond
// assumes clk_sys at the rate given in the package
`timescale 1ns/1ns
module plrt_tick_gen
  import plrt_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  // time base out
  plrt_tick_if.src    tick_o
);

  logic [TICK_CNT_W-1:0] div_r;
  logic [TICK_CNT_W-1:0] div_nxt;
  logic                  tick_r;
  logic                  tick_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = div_r + TICK_CNT_W'(1);
    if (div_r == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o.tick = tick_r;

endmodule : plrt_tick_gen

/* logic/plrt_top.sv */
// long-press detector: one active-low button in, one open-drain reset pulse out
// assumes the button pin and strap pin are asynchronous to clk_sys and that
// rst_n is the power-on reset; the pad resolves the open-drain output
`timescale 1ns/1ns

module plrt_top
  import plrt_pkg::*;
#(
  parameter logic [TIMER_W-1:0] HOLD_TICKS_P    = TIMER_W'(HOLD_TICKS),
  parameter logic [TIMER_W-1:0] PULSE_TICKS_P   = TIMER_W'(PULSE_TICKS),
  parameter logic [TIMER_W-1:0] DETECT_TICKS_P  = TIMER_W'(DETECT_TICKS),
  parameter logic [TIMER_W-1:0] STARTUP_TICKS_P = TIMER_W'(STARTUP_TICKS)
) (
  // clock and power-on reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // pins in
  input  wire logic button_in_n,
  input  wire logic delay_select_strap,
  // open-drain reset pin
  output logic      reset_out,
  output logic      reset_out_oe,
  // button pad pull-up control
  output logic      button_pull_en
);

  ////////////////////////////////////////////////////////////////////////////
  // time base
  plrt_tick_if tick_bus ();

  plrt_tick_gen u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick_o  (tick_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 button, bit 1 strap
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync1_nxt;
  logic [1:0] sync2_nxt;

  always_comb begin
    sync1_nxt = {delay_select_strap, button_in_n};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= {SYNC_STAGES{SYNC_RESET}};
      sync2_r <= {SYNC_STAGES{SYNC_RESET}};
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  logic btn_low;
  logic strap_s;
  assign btn_low = ~sync2_r[0];
  assign strap_s = sync2_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  plrt_state_t        state_r;
  plrt_state_t        state_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic               zero_mode_r;
  logic               zero_mode_nxt;
  logic               oe_r;
  logic               oe_nxt;
  logic               pull_r;
  logic               pull_nxt;
  logic [TIMER_W-1:0] hold_limit;
  logic [TIMER_W-1:0] timer_inc;

  assign hold_limit = zero_mode_r ? DETECT_TICKS_P : HOLD_TICKS_P;
  assign timer_inc  = tick_bus.tick ? timer_r + TIMER_W'(1) : timer_r;

  always_comb begin
    state_nxt     = state_r;
    timer_nxt     = timer_inc;
    zero_mode_nxt = zero_mode_r;
    oe_nxt        = oe_r;
    pull_nxt      = 1'b1;
    case (state_r)
      ST_STARTUP: begin
        if (timer_r >= STARTUP_TICKS_P) begin
          zero_mode_nxt = strap_s;
          timer_nxt     = '0;
          state_nxt     = ST_IDLE;
        end
      end
      ST_IDLE: begin
        timer_nxt = '0;
        if (btn_low) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!btn_low) begin
          timer_nxt = '0;
          state_nxt = ST_IDLE;
        end else if (timer_r > hold_limit) begin
          // held past threshold, assert
          // strictly past: the first tick after entry is only partial
          timer_nxt = '0;
          oe_nxt    = 1'b1;
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (timer_r >= PULSE_TICKS_P) begin
          oe_nxt    = 1'b0;
          timer_nxt = '0;
          state_nxt = ST_WAIT_REL;
        end
      end
      ST_WAIT_REL: begin
        timer_nxt = '0;
        if (!btn_low) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        timer_nxt = '0;
        oe_nxt    = 1'b0;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_STARTUP;
      timer_r     <= '0;
      zero_mode_r <= STRAP_RESET;
      oe_r        <= OE_RESET;
      pull_r      <= PULL_EN_RESET;
    end else begin
      state_r     <= state_nxt;
      timer_r     <= timer_nxt;
      zero_mode_r <= zero_mode_nxt;
      oe_r        <= oe_nxt;
      pull_r      <= pull_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: level is always low, only the enable moves
  logic out_lvl_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_lvl_r <= 1'b0;
    end else begin
      out_lvl_r <= 1'b0;
    end
  end

  assign reset_out      = out_lvl_r;
  assign reset_out_oe   = oe_r;
  assign button_pull_en = pull_r;

endmodule : plrt_top

/* verification/plrt_sva.sv */
// port checker for the long-press reset timer
// assumes rst_n is the power-on reset
`timescale 1ns/1ns
module plrt_sva
  import plrt_pkg::*;
#(
  parameter logic [TIMER_W-1:0] HOLD_TICKS_P    = 1,
  parameter logic [TIMER_W-1:0] PULSE_TICKS_P   = 1,
  parameter logic [TIMER_W-1:0] DETECT_TICKS_P  = 1,
  parameter logic [TIMER_W-1:0] STARTUP_TICKS_P = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins
  input wire logic button_in_n,
  input wire logic delay_select_strap,
  input wire logic reset_out,
  input wire logic reset_out_oe,
  input wire logic button_pull_en
);
  int   lo_r, lo_nxt, hi_r, hi_nxt, up_r, up_nxt;
  logic armed_r, armed_nxt;
  always_comb begin
    lo_nxt    = button_in_n ? 0 : lo_r + 1;
    hi_nxt    = reset_out_oe ? hi_r + 1 : 0;
    up_nxt    = (up_r < 99999) ? up_r + 1 : up_r;
    armed_nxt = reset_out_oe ? 1'h0 : (button_in_n ? 1'h1 : armed_r);
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo_r    <= 0;
      hi_r    <= 0;
      up_r    <= 0;
      armed_r <= 1'h1;
    end else begin
      lo_r    <= lo_nxt;
      hi_r    <= hi_nxt;
      up_r    <= up_nxt;
      armed_r <= armed_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pin_low: assert property (reset_out == 1'h0)
    else $error("reset pin driven high");
  a_pull_on: assert property (button_pull_en)
    else $error("button pull-up off");
  a_no_early: assert property ($rose(reset_out_oe) |->
    lo_r >= (delay_select_strap ? DETECT_TICKS_P : HOLD_TICKS_P) * TICK_CYCLES)
    else $error("reset before hold time");
  a_pulse_min: assert property ($fell(reset_out_oe) |-> hi_r >= (PULSE_TICKS_P - 1) * 100)
    else $error("pulse too short");
  a_pulse_max: assert property (hi_r <= (PULSE_TICKS_P + 1) * 100)
    else $error("pulse too long");
  a_one_press: assert property ($rose(reset_out_oe) |-> armed_r)
    else $error("second pulse without release");
  a_quiet_up: assert property (reset_out_oe |->
    up_r >= (STARTUP_TICKS_P + DETECT_TICKS_P - 1) * 100)
    else $error("reset during start-up");
  a_pulse_hold: assert property ($rose(reset_out_oe) |=> reset_out_oe [*8])
    else $error("pulse broken early");
endmodule : plrt_sva

bind plrt_top plrt_sva #(.HOLD_TICKS_P(HOLD_TICKS_P), .PULSE_TICKS_P(PULSE_TICKS_P),
  .DETECT_TICKS_P(DETECT_TICKS_P),
  .STARTUP_TICKS_P(STARTUP_TICKS_P)) sva_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .button_in_n(button_in_n), .delay_select_strap(delay_select_strap), .reset_out(reset_out),
  .reset_out_oe(reset_out_oe), .button_pull_en(button_pull_en));

/* verification/plrt_button_model.sv */
// switch and host reset net on the timer's pins
// assumes press comes from the bench
`timescale 1ns/1ns
module plrt_button_model (
  // bench side
  input  wire logic press,
  // timer pins
  input  wire logic button_pull_en,
  input  wire logic reset_out,
  input  wire logic reset_out_oe,
  output logic      button_in_n,
  // host net
  output logic      host_rst_n
);
  assign button_in_n = press ? 1'h0 : button_pull_en;
  assign host_rst_n  = reset_out_oe ? reset_out : 1'h1;
endmodule : plrt_button_model

/* verification/plrt_top_bench.sv */
// self-checking bench for the long-press reset timer
// assumes shortened tick counts; one tick is 100 clocks
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module plrt_top_bench;
  localparam int HT = 20, PT = 10, DT = 5, ST = 5, TC = 100;
  logic clk_sys = 1'h0, rst_n = 1'h0, strap = 1'h0, press = 1'h0;
  logic button_in_n, reset_out, reset_out_oe, button_pull_en, host_rst_n;
  int   num_errors = 0, tests_run = 0, cyc = 0, n;
  always #5 clk_sys = ~clk_sys;
  plrt_top #(.HOLD_TICKS_P(HT), .PULSE_TICKS_P(PT), .DETECT_TICKS_P(DT),
    .STARTUP_TICKS_P(ST)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .button_in_n(button_in_n), .delay_select_strap(strap), .reset_out(reset_out),
    .reset_out_oe(reset_out_oe), .button_pull_en(button_pull_en));
  plrt_button_model pin (.press(press), .button_pull_en(button_pull_en),
    .reset_out(reset_out), .reset_out_oe(reset_out_oe), .button_in_n(button_in_n),
    .host_rst_n(host_rst_n));
  task automatic end_of_test;
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task automatic power_up(input logic s);
    rst_n <= 1'h0;
    strap <= s;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
  endtask : power_up
  task automatic wait_oe(input logic lvl, input int lim);
    n = 0;
    while (reset_out_oe !== lvl && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // back onto the edge so later drives land on it
    @(posedge clk_sys);
  endtask : wait_oe
  task automatic t_hold_mode;
    power_up(1'h0);
    repeat ((ST + 2) * TC) @(posedge clk_sys);
    `CHK("idle drive", 1'h0, reset_out_oe)
    `CHK("released pin", 1'h1, button_in_n)
    press <= 1'h1;
    repeat ((HT - 2) * TC) @(posedge clk_sys);
    press <= 1'h0;
    repeat (5) @(posedge clk_sys);
    `CHK("early release", 1'h0, reset_out_oe)
    press <= 1'h1;
    wait_oe(1'h1, (HT + 4) * TC);
    `CHK("hold delay", 1'h1, n >= HT * TC && n <= (HT + 2) * TC + 10)
    wait_oe(1'h0, (PT + 4) * TC);
    wait_oe(1'h1, 3 * HT * TC);
    `CHK("single pulse", 1'h0, reset_out_oe)
    press <= 1'h0;
  endtask : t_hold_mode
  task automatic t_zero_mode;
    power_up(1'h1);
    repeat ((ST + 2) * TC) @(posedge clk_sys);
    press <= 1'h1;
    wait_oe(1'h1, (DT + 4) * TC);
    `CHK("detect delay", 1'h1, n >= DT * TC && n <= (DT + 2) * TC + 10)
    `CHK("host net", 1'h0, host_rst_n)
    press <= 1'h0;
    wait_oe(1'h0, (PT + 4) * TC);
    `CHK("pulse width", 1'h1, n >= (PT - 1) * TC && n <= (PT + 1) * TC)
    @(posedge clk_sys);
    press <= 1'h1;
    wait_oe(1'h1, (DT + 4) * TC);
    `CHK("strap kept", 1'h1, n >= DT * TC && n <= (DT + 2) * TC + 10)
    press <= 1'h0;
    wait_oe(1'h0, (PT + 4) * TC);
  endtask : t_zero_mode
  task automatic t_press_at_power_up;
    press <= 1'h1;
    power_up(1'h1);
    wait_oe(1'h1, (ST + DT + 4) * TC);
    `CHK("power-up delay", 1'h1, n >= (ST + DT - 1) * TC && n <= (ST + DT + 3) * TC)
    `CHK("pin level", 1'h0, reset_out)
    press <= 1'h0;
    wait_oe(1'h0, (PT + 4) * TC);
  endtask : t_press_at_power_up
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    t_hold_mode();
    t_zero_mode();
    t_press_at_power_up();
    end_of_test();
  end
endmodule : plrt_top_bench
